/* File: por_timer.sv */
// power-on reset release timer
// assumes supply_ok comes from an analog comparator, asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module por_timer #(
	parameter longint POR_CYCLES = spi_port_pkg::POR_CYCLES
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// supply monitor
	input  wire logic supply_ok,
	// release
	output logic      por_done
);

	logic                               sup_meta_reg;
	logic                               sup_sync_reg;
	logic [spi_port_pkg::POR_CNT_W-1:0] cnt_reg;
	logic [spi_port_pkg::POR_CNT_W-1:0] cnt_next;
	logic                               done_reg;
	logic                               done_next;

	localparam logic [spi_port_pkg::POR_CNT_W-1:0] CNT_END =
		spi_port_pkg::POR_CNT_W'(POR_CYCLES - 64'd1);

	always_comb begin
		cnt_next  = cnt_reg;
		done_next = done_reg;
		if (!sup_sync_reg) begin
			// held in reset while the supply sits below threshold
			cnt_next  = '0;
			done_next = 1'b0;
		end else if (!done_reg) begin
			if (cnt_reg == CNT_END) begin
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		sup_meta_reg <= supply_ok;
		sup_sync_reg <= sup_meta_reg;
		if (!rst_n) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign por_done = done_reg;

endmodule
`default_nettype wire

/* File: spi_master_model.sv */
// serial master model: clock only runs inside a frame
// assumes the bench calls xfer with a gap between frames
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
	output logic      link_sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	initial begin
		link_sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// sends the top n bits of w, msb first; r holds what came back
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		#7 cs_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			din = w[i];
			#16 link_sclk = 1'b1;
			#16 link_sclk = 1'b0;
			r[i] = dout_oe ? dout : 1'bx;
		end
		#16 cs_n = 1'b1;
		din = ~din;
	endtask
endmodule
`default_nettype wire

/* File: spi_port_pkg.sv */
// constants, types and the command word layout of the serial slave port
// assumes a 50 MHz system clock and a master that sends 16-bit words
package spi_port_pkg;

	localparam int          WORD_BITS    = 16;
	localparam int          BIT_CNT_W    = 4;
	localparam int          ADDR_BITS    = 7;
	localparam int          DATA_BITS    = 8;
	localparam logic [3:0]  LAST_BIT     = 4'hf;
	localparam logic [15:0] RESP_RESET   = 16'h0000;
	localparam logic [15:0] WORD_RESET   = 16'h0000;

	// power-on release timer
	localparam longint      SYS_CLK_HZ   = 64'd50000000;
	localparam longint      POR_TIME_MS  = 64'd130;
	localparam longint      POR_CYCLES   = (SYS_CLK_HZ * POR_TIME_MS) / 64'd1000;
	localparam int          POR_CNT_W    = 23;

	// first byte: write flag and address, second byte: data
	typedef struct packed {
		logic                 write;
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} cmd_s;

	typedef enum logic [1:0] {
		CORE_IDLE,
		CORE_DECODE,
		CORE_CAPTURE
	} core_state_e;

endpackage

/* File: spi_reg_slave.sv */
// serial register access slave port: link logic on the serial clock,
// command decode and core register strobes on sys_clk
// assumes the core answers a read strobe with data on the next sys_clk
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module spi_reg_slave #(
	parameter longint POR_CYCLES = spi_port_pkg::POR_CYCLES
) (
	// system clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst_n,
	input  wire logic                               supply_ok,
	// serial link: sclk, select and data in from the master, data out and its enable to the master
	input  wire logic                               link_sclk,
	input  wire logic                               cs_n,
	input  wire logic                               din,
	output logic                                    dout,
	output logic                                    dout_oe,
	// core register access
	output logic                                    reg_wr,
	output logic                                    reg_rd,
	output logic [spi_port_pkg::ADDR_BITS-1:0]      reg_addr,
	output logic [spi_port_pkg::DATA_BITS-1:0]      reg_wdata,
	input  wire logic [spi_port_pkg::WORD_BITS-1:0] reg_rdata,
	// status
	output logic                                    port_ready
);

	////////////////////////////////////////////////////////////////////////
	// power-on release

	logic por_done;
	logic core_rst_n;
	logic link_rst_n_reg;

	por_timer #(
		.POR_CYCLES (POR_CYCLES)
	) u_por (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.supply_ok (supply_ok),
		.por_done  (por_done)
	);

	assign core_rst_n = rst_n & por_done;

	////////////////////////////////////////////////////////////////////////
	// link side, frame state cleared while select is high

	logic [spi_port_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
	logic [spi_port_pkg::BIT_CNT_W-1:0] bit_cnt_next;
	logic [spi_port_pkg::WORD_BITS-1:0] rx_reg;
	logic [spi_port_pkg::WORD_BITS-1:0] rx_next;
	logic [spi_port_pkg::WORD_BITS-1:0] tx_reg;
	logic [spi_port_pkg::WORD_BITS-1:0] tx_next;
	logic                               dout_reg;
	logic                               dout_next;
	logic                               oe_reg;
	logic                               oe_next;
	logic [spi_port_pkg::WORD_BITS-1:0] hold_reg;
	logic [spi_port_pkg::WORD_BITS-1:0] hold_next;
	logic                               tgl_reg;
	logic                               tgl_next;
	logic [spi_port_pkg::WORD_BITS-1:0] resp_reg;

	always_comb begin
		bit_cnt_next = bit_cnt_reg + 1'b1;
		rx_next      = {rx_reg[spi_port_pkg::WORD_BITS-2:0], din};
		oe_next      = 1'b1;
		hold_next    = hold_reg;
		tgl_next     = tgl_reg;
		if (bit_cnt_reg == '0) begin
			// resp_reg is quiet while a frame runs
			dout_next = resp_reg[spi_port_pkg::WORD_BITS-1];
			tx_next   = {resp_reg[spi_port_pkg::WORD_BITS-2:0], 1'b0};
		end else begin
			dout_next = tx_reg[spi_port_pkg::WORD_BITS-1];
			tx_next   = {tx_reg[spi_port_pkg::WORD_BITS-2:0], 1'b0};
		end
		if (bit_cnt_reg == spi_port_pkg::LAST_BIT) begin
			hold_next = rx_next;
			tgl_next  = ~tgl_reg;
		end
	end

	always_ff @(posedge link_sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= '0;
			rx_reg      <= spi_port_pkg::WORD_RESET;
			tx_reg      <= spi_port_pkg::WORD_RESET;
			dout_reg    <= 1'b0;
			oe_reg      <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			rx_reg      <= rx_next;
			tx_reg      <= tx_next;
			dout_reg    <= dout_next;
			oe_reg      <= oe_next;
		end
	end

	always_ff @(posedge link_sclk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			hold_reg <= spi_port_pkg::WORD_RESET;
			tgl_reg  <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			tgl_reg  <= tgl_next;
		end
	end

	assign dout    = dout_reg;
	assign dout_oe = oe_reg;

	////////////////////////////////////////////////////////////////////////
	// core side: word arrival by toggle, decode, register strobes

	logic                      tgl_meta_reg;
	logic                      tgl_sync_reg;
	logic                      tgl_seen_reg;
	logic                      tgl_seen_next;
	spi_port_pkg::core_state_e state_reg;
	spi_port_pkg::core_state_e state_next;
	spi_port_pkg::cmd_s        cmd_reg;
	spi_port_pkg::cmd_s        cmd_next;
	logic [spi_port_pkg::WORD_BITS-1:0] resp_next;
	logic                      wr_reg;
	logic                      wr_next;
	logic                      rd_reg;
	logic                      rd_next;
	logic                      ready_reg;

	always_comb begin
		state_next    = state_reg;
		cmd_next      = cmd_reg;
		resp_next     = resp_reg;
		tgl_seen_next = tgl_seen_reg;
		wr_next       = 1'b0;
		rd_next       = 1'b0;
		case (state_reg)
			spi_port_pkg::CORE_IDLE: begin
				if (tgl_sync_reg != tgl_seen_reg) begin
					tgl_seen_next = tgl_sync_reg;
					cmd_next      = spi_port_pkg::cmd_s'(hold_reg);
					state_next    = spi_port_pkg::CORE_DECODE;
				end
			end
			spi_port_pkg::CORE_DECODE: begin
				if (cmd_reg.write) begin
					wr_next    = 1'b1;
					resp_next  = spi_port_pkg::RESP_RESET;
					state_next = spi_port_pkg::CORE_IDLE;
				end else begin
					rd_next    = 1'b1;
					state_next = spi_port_pkg::CORE_CAPTURE;
				end
			end
			spi_port_pkg::CORE_CAPTURE: begin
				resp_next  = reg_rdata;
				state_next = spi_port_pkg::CORE_IDLE;
			end
			default: begin
				state_next = spi_port_pkg::CORE_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		tgl_meta_reg   <= tgl_reg;
		tgl_sync_reg   <= tgl_meta_reg;
		link_rst_n_reg <= core_rst_n;
		if (!core_rst_n) begin
			state_reg    <= spi_port_pkg::CORE_IDLE;
			cmd_reg      <= spi_port_pkg::cmd_s'(spi_port_pkg::WORD_RESET);
			resp_reg     <= spi_port_pkg::RESP_RESET;
			tgl_seen_reg <= 1'b0;
			wr_reg       <= 1'b0;
			rd_reg       <= 1'b0;
			ready_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cmd_reg      <= cmd_next;
			resp_reg     <= resp_next;
			tgl_seen_reg <= tgl_seen_next;
			wr_reg       <= wr_next;
			rd_reg       <= rd_next;
			ready_reg    <= 1'b1;
		end
	end

	assign reg_wr     = wr_reg;
	assign reg_rd     = rd_reg;
	assign reg_addr   = cmd_reg.addr;
	assign reg_wdata  = cmd_reg.data;
	assign port_ready = ready_reg;

endmodule
`default_nettype wire

/* File: spi_reg_slave_bench.sv */
// bench for the serial slave port with a master model and a core stub
// assumes the package, the design and the master model compile first
`timescale 1ns/100ps
`default_nettype none

module spi_reg_slave_bench;
	logic                               sys_clk = 1'b0;
	logic                               rst_n = 1'b0;
	logic                               supply_ok = 1'b1;
	logic                               link_sclk, cs_n, din, dout, dout_oe;
	logic                               reg_wr, reg_rd, port_ready;
	logic [spi_port_pkg::ADDR_BITS-1:0] reg_addr;
	logic [spi_port_pkg::DATA_BITS-1:0] reg_wdata;
	logic [15:0]                        reg_rdata = 16'h0000;
	logic [15:0]                        got;
	int                                 n_fail = 0, samples_checked = 0;
	int                                 n_wr = 0, n_rd = 0;

	spi_reg_slave #(.POR_CYCLES(16)) i_spi_reg_slave (.*);
	spi_master_model i_spi_master_model (.*);

	always #10 sys_clk = ~sys_clk;

	// core stub answers each address with a pattern built from it
	always @(posedge sys_clk) begin
		reg_rdata <= {8'ha5, 1'b0, reg_addr};
		n_wr <= n_wr + int'(reg_wr);
		n_rd <= n_rd + int'(reg_rd);
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic frame(input logic [15:0] w, input int n);
		i_spi_master_model.xfer(w, n, got);
		repeat (20) @(posedge sys_clk);
	endtask

	task automatic t_write;
		frame(16'hab5c, 16);
		chk({1'b0, reg_addr, reg_wdata}, 16'h2b5c);
		chk({n_wr[7:0], n_rd[7:0]}, 16'h0100);
	endtask

	task automatic t_read;
		frame(16'h1300, 16);
		chk(got, 16'h0000);
		frame(16'h7f00, 16);
		chk(got, 16'ha513);
		frame(16'h8000, 16);
		chk(got, 16'ha57f);
		chk({n_wr[7:0], n_rd[7:0]}, 16'h0202);
	endtask

	task automatic t_partial;
		frame(16'h9100, 8);
		chk({n_wr[7:0], n_rd[7:0]}, 16'h0202);
	endtask

	task automatic t_por;
		supply_ok <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk({15'h0000, port_ready}, 16'h0000);
		supply_ok <= 1'b1;
		repeat (16) @(posedge sys_clk);
		chk({15'h0000, port_ready}, 16'h0000);
		repeat (8) @(posedge sys_clk);
		chk({15'h0000, port_ready}, 16'h0001);
	endtask

	task automatic final_report;
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 40 && port_ready !== 1'b1; i++)
			@(posedge sys_clk);
		chk({15'h0000, port_ready}, 16'h0001);
		repeat (2) @(posedge sys_clk);
		t_write;
		t_read;
		t_partial;
		t_por;
		final_report;
	end

	initial begin
		#100000;
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire

/* File: spi_reg_slave_props.sv */
// assertions on the ports of the serial slave port
// assumes rst_n is synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module spi_reg_slave_props (
	input wire logic                               sys_clk,
	input wire logic                               rst_n,
	input wire logic                               cs_n,
	input wire logic                               dout,
	input wire logic                               dout_oe,
	input wire logic                               reg_wr,
	input wire logic                               reg_rd,
	input wire logic [spi_port_pkg::ADDR_BITS-1:0] reg_addr,
	input wire logic [spi_port_pkg::DATA_BITS-1:0] reg_wdata,
	input wire logic                               port_ready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_wr_one_pulse: assert property (
		reg_wr |=> !reg_wr)
		else $error("write strobe too long");
	a_rd_one_pulse: assert property (
		reg_rd |=> !reg_rd)
		else $error("read strobe too long");
	a_strobe_gap: assert property (
		(reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*2])
		else $error("strobes too close");
	a_strobe_ready: assert property (
		(reg_wr || reg_rd) |-> port_ready)
		else $error("strobe while in reset");
	a_addr_hold: assert property (
		port_ready && $changed(reg_addr) |=> reg_wr || reg_rd)
		else $error("address moved without command");
	a_data_hold: assert property (
		port_ready && $changed(reg_wdata) |=> reg_wr || reg_rd)
		else $error("data moved without command");
	a_oe_idle: assert property (
		cs_n && $past(cs_n) |-> !dout_oe && !dout)
		else $error("output driven outside frame");
	a_oe_in_frame: assert property (
		$rose(dout_oe) |-> !cs_n)
		else $error("output enabled without select");
endmodule

bind spi_reg_slave spi_reg_slave_props i_props (.*);
`default_nettype wire
